// File: design/fmr_top.sv
// Overview of operation
// - An out-of-range monitor either forces a security reset or raises an exception.
// - With inverse EEPROM correction enabled, a detected read error raises an exception.
// - RAM words carry per-byte parity that is checked on every read.
// - A scrubber checks all RAM in random order only while software leaves RAM idle.
// - Parity errors from reads or from the scrubber force a security reset.
// - Reset returns every piece of state except rst_cause to its defined value; of the two resets only por_n loads rst_cause.
// - After a reset software can read what caused it.
// - Each raised exception leaves a readable reason bit.
// - Software cannot switch any sensor off; such writes do nothing.
// - User, system and super system modes each own a stack pointer and limit check.
// - The active stack pointer leaving its range raises an exception.
// - Write-voltage checks land in a readable status register and raise nothing.
// - Software turns the EEPROM double-read function on or off.
// - The watchdog stays off until software enables and configures it.
// - Fault detection on key units forces a security reset.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`default_nettype none
module fmr_top #(
  parameter int unsigned N_SENS = 8,
  parameter int unsigned WD_W   = 32,
  parameter int unsigned RAM_AW = 8
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          por_n,
  input  wire logic                          ce,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [N_SENS-1:0]             sens_oor,
  input  wire logic [fmr_pkg::FI_N-1:0]      fi_err,
  input  wire logic                          inv_ecc_en,
  input  wire logic                          ecc_err,
  input  wire logic [1:0]                    cpu_mode,
  input  wire logic                          sp_ld,
  input  wire logic [fmr_pkg::SP_W-1:0]      sp_in,
  input  wire logic                          ram_rd_valid,
  input  wire logic [fmr_pkg::RAM_DW-1:0]    ram_rd_data,
  input  wire logic [fmr_pkg::RAM_PW-1:0]    ram_rd_par,
  input  wire logic                          cpu_ram_busy,
  input  wire logic                          cpu_wr_en,
  input  wire logic [RAM_AW-1:0]             cpu_wr_addr,
  input  wire logic [fmr_pkg::RAM_DW-1:0]    cpu_wr_data,
  output logic                               ram_we,
  output logic      [RAM_AW-1:0]             ram_waddr,
  output logic      [fmr_pkg::RAM_DW-1:0]    ram_wdata,
  output logic      [fmr_pkg::RAM_PW-1:0]    ram_wpar,
  output logic                               scrub_req,
  output logic      [RAM_AW-1:0]             scrub_addr,
  input  wire logic                          scrub_rvalid,
  input  wire logic [fmr_pkg::RAM_DW-1:0]    scrub_rdata,
  input  wire logic [fmr_pkg::RAM_PW-1:0]    scrub_rpar,
  input  wire logic                          ee_wr_seq,
  input  wire logic                          hv_low,
  output logic                               ee_dbl_rd_en,
  output logic                               sec_rst,
  output logic      [2:0]                    rst_cause,
  output logic                               exc_req,
  output logic      [fmr_pkg::EXC_W-1:0]     exc_cause,
  output logic      [fmr_pkg::SP_W-1:0]      sp_cur
);
  if (N_SENS < 1 || N_SENS > 16 || WD_W < 1 || WD_W > 32) begin : g_chk
    $error("fmr_top: N_SENS must be 1..16 and WD_W 1..32");
  end

  localparam int unsigned EW = fmr_pkg::EXC_W;

  fmr_pkg::fmr_wst_t wst_r;
  logic              aw_got_r, w_got_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [1:0]        ctrl_r;
  logic [WD_W-1:0]   wd_load_r, wd_cnt_r;
  logic [N_SENS-1:0] action_r;
  logic [EW-1:0]     exc_r;
  logic [2:0]        hv_r;
  logic              seq_d_r;
  fmr_pkg::fmr_lim_t lim_r [fmr_pkg::N_MODE];
  logic [fmr_pkg::SP_W-1:0] sp_v [fmr_pkg::N_MODE];
  logic [fmr_pkg::N_MODE-1:0] stk_viol;
  logic              scrub_err;

  // bus handshakes and decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire aw_nxt  = aw_got_r || aw_take;
  wire w_nxt   = w_got_r || w_take;
  wire wr_fire = (wst_r == fmr_pkg::WS_IDLE) && aw_got_r && w_got_r;
  wire b_done  = s_axi_bvalid && s_axi_bready;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits = wdata_r & wmask;

  function automatic logic sel(input logic [7:0] off);
    return wr_fire && (awaddr_r == off);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | wbits;
  endfunction

  wire wr_ctrl   = sel(fmr_pkg::OFF_CTRL);
  wire wr_wdload = sel(fmr_pkg::OFF_WDLOAD);
  wire wr_kick   = sel(fmr_pkg::OFF_WDKICK);
  wire wr_exc    = sel(fmr_pkg::OFF_EXCCAUSE);
  wire wr_action = sel(fmr_pkg::OFF_ACTION);
  wire [31:0] ctrl_m = merge({30'h0000_0000, ctrl_r});
  wire [31:0] wdload_m = merge(32'(wd_load_r));
  wire [31:0] action_m = merge(32'(action_r));

  // event sources
  wire sens_rst = |(sens_oor & action_r);
  wire sens_exc = |(sens_oor & ~action_r);
  wire fi_any   = |fi_err;
  wire rd_perr  = ram_rd_valid && (fmr_pkg::par(ram_rd_data) != ram_rd_par);
  wire par_any  = rd_perr || scrub_err;
  wire wd_exp   = ctrl_r[fmr_pkg::CTRL_WDEN] && (wd_cnt_r == '0) && !wr_kick;
  wire rst_any  = sens_rst || fi_any || par_any || wd_exp;
  wire [2:0] cause_nxt = par_any  ? fmr_pkg::CAUSE_PARITY :
                         fi_any   ? fmr_pkg::CAUSE_FAULT  :
                         sens_rst ? fmr_pkg::CAUSE_SENS   : fmr_pkg::CAUSE_WDOG;
  wire [EW-1:0] exc_set = {stk_viol, inv_ecc_en && ecc_err, sens_exc};
  wire [EW-1:0] exc_clr = wr_exc ? wbits[EW-1:0] : '0;
  wire [EW-1:0] exc_nxt = exc_set | (exc_r & ~exc_clr);

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      fmr_pkg::OFF_CTRL:     return {30'h0000_0000, ctrl_r};
      fmr_pkg::OFF_SENS:     return 32'({N_SENS{1'b1}});
      fmr_pkg::OFF_WDLOAD:   return 32'(wd_load_r);
      fmr_pkg::OFF_WDKICK:   return 32'(wd_cnt_r);
      fmr_pkg::OFF_RSTCAUSE: return {29'h0000_0000, rst_cause};
      fmr_pkg::OFF_EXCCAUSE: return 32'(exc_r);
      fmr_pkg::OFF_HVSTAT:   return {29'h0000_0000, hv_r};
      fmr_pkg::OFF_ACTION:   return 32'(action_r);
      fmr_pkg::OFF_SPLIM0:   return lim_r[0];
      fmr_pkg::OFF_SPLIM1:   return lim_r[1];
      fmr_pkg::OFF_SPLIM2:   return lim_r[2];
      default:               return 32'h0000_0000;
    endcase
  endfunction

  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r         <= fmr_pkg::WS_IDLE;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= fmr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      case (wst_r)
        fmr_pkg::WS_IDLE: begin
          aw_got_r      <= aw_nxt;
          w_got_r       <= w_nxt;
          s_axi_awready <= !aw_nxt;
          s_axi_wready  <= !w_nxt;
          if (wr_fire) begin
            wst_r         <= fmr_pkg::WS_RESP;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= fmr_pkg::is_mapped(awaddr_r) ? fmr_pkg::RESP_OKAY
                                                          : fmr_pkg::RESP_SLVERR;
          end
        end
        fmr_pkg::WS_RESP: begin
          if (b_done) begin
            wst_r         <= fmr_pkg::WS_IDLE;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
        default: wst_r <= fmr_pkg::WS_IDLE;
      endcase
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= fmr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux(s_axi_araddr);
        s_axi_rresp   <= fmr_pkg::is_mapped(s_axi_araddr) ? fmr_pkg::RESP_OKAY
                                                          : fmr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= fmr_pkg::CTRL_RST;
      wd_load_r <= fmr_pkg::WDLOAD_RST[WD_W-1:0];
      action_r  <= fmr_pkg::ACTION_RST[N_SENS-1:0];
      lim_r     <= '{default: fmr_pkg::LIM_RST};
    end else if (ce) begin
      if (wr_ctrl) ctrl_r[fmr_pkg::CTRL_DBLRD] <= ctrl_m[fmr_pkg::CTRL_DBLRD];
      if (wr_ctrl && ctrl_m[fmr_pkg::CTRL_WDEN]) ctrl_r[fmr_pkg::CTRL_WDEN] <= 1'b1;
      if (wr_wdload) wd_load_r <= wdload_m[WD_W-1:0];
      if (wr_action) action_r <= action_m[N_SENS-1:0];
      for (int k = 0; k < fmr_pkg::N_MODE; k++) begin
        if (sel(8'(fmr_pkg::OFF_SPLIM0 + 4 * k))) lim_r[k] <= merge(lim_r[k]);
      end
    end
  end

  // supervision state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt_r     <= fmr_pkg::WDLOAD_RST[WD_W-1:0];
      exc_r        <= '0;
      exc_req      <= 1'b0;
      exc_cause    <= '0;
      hv_r         <= 3'h0;
      seq_d_r      <= 1'b0;
      sec_rst      <= 1'b0;
      ee_dbl_rd_en <= 1'b0;
      sp_cur       <= '0;
      ram_we       <= 1'b0;
      ram_waddr    <= '0;
      ram_wdata    <= '0;
      ram_wpar     <= '0;
    end else if (ce) begin
      if (!ctrl_r[fmr_pkg::CTRL_WDEN] || wr_kick || wd_cnt_r == '0) wd_cnt_r <= wd_load_r;
      else wd_cnt_r <= wd_cnt_r - 1'b1;
      exc_r     <= exc_nxt;
      exc_cause <= exc_nxt;
      exc_req   <= |exc_nxt;
      seq_d_r <= ee_wr_seq;
      if (ee_wr_seq && !seq_d_r) hv_r <= {hv_low, 1'b0, 1'b1};
      else if (ee_wr_seq) hv_r[fmr_pkg::HV_FAIL] <= hv_r[fmr_pkg::HV_FAIL] | hv_low;
      else if (seq_d_r) hv_r[fmr_pkg::HV_DONE +: 2] <= {hv_r[fmr_pkg::HV_FAIL], 1'b1};
      if (!ee_wr_seq) hv_r[fmr_pkg::HV_BUSY] <= 1'b0;
      sec_rst      <= rst_any;
      ee_dbl_rd_en <= ctrl_r[fmr_pkg::CTRL_DBLRD];
      sp_cur       <= (cpu_mode < 2'(fmr_pkg::N_MODE)) ? sp_v[cpu_mode] : '0;
      ram_we    <= cpu_wr_en;
      ram_waddr <= cpu_wr_addr;
      ram_wdata <= cpu_wr_data;
      ram_wpar  <= fmr_pkg::par(cpu_wr_data);
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) rst_cause <= fmr_pkg::CAUSE_POR;
    else if (ce && rst_any) rst_cause <= cause_nxt;
  end

  for (genvar k = 0; k < fmr_pkg::N_MODE; k++) begin : g_stk
    fmr_stack u_stk (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .act     (cpu_mode == 2'(k)),
      .sp_ld   (sp_ld),
      .sp_in   (sp_in),
      .lim     (lim_r[k]),
      .sp_r    (sp_v[k]),
      .viol_r  (stk_viol[k])
    );
  end

  fmr_scrub #(.AW(RAM_AW)) u_scrub (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .cpu_busy (cpu_ram_busy),
    .rvalid   (scrub_rvalid),
    .rdata    (scrub_rdata),
    .rpar     (scrub_rpar),
    .req_r    (scrub_req),
    .addr_r   (scrub_addr),
    .err_r    (scrub_err)
  );

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sens_action_a: assert property (ce && sens_rst |=> sec_rst)
    else $error("sensor reset not forced");
  ecc_exc_a: assert property (ce && inv_ecc_en && ecc_err |=> exc_r[fmr_pkg::EXC_ECC] && exc_req)
    else $error("ecc exception missing");
  read_parity_a: assert property (ce && rd_perr |=> sec_rst && rst_cause == fmr_pkg::CAUSE_PARITY)
    else $error("read parity error not reset");
  scrub_reset_a: assert property (ce && scrub_err |=> sec_rst)
    else $error("scrub error not reset");
  cause_keep_a: assert property (por_n && !rst_any |=> $stable(rst_cause))
    else $error("reset cause changed without event");
  exc_sticky_a: assert property (ce && exc_r[0] && !wr_exc |=> exc_r[0])
    else $error("exception reason lost");
  sens_on_a: assert property (ce && ar_take && s_axi_araddr == fmr_pkg::OFF_SENS |=> s_axi_rdata == 32'({N_SENS{1'b1}}))
    else $error("sensor enable read not all on");
  stk_exc_a: assert property (ce && |stk_viol |=> |exc_r[fmr_pkg::EXC_STK0 +: 3])
    else $error("stack violation without exception");
  hv_fail_a: assert property (ce && ee_wr_seq && seq_d_r && hv_low |=> hv_r[fmr_pkg::HV_FAIL])
    else $error("high voltage failure not recorded");
  wd_off_a: assert property (
    ce && !ctrl_r[fmr_pkg::CTRL_WDEN] && !wr_wdload |=> wd_cnt_r == wd_load_r)
    else $error("watchdog counted while disabled");
  wd_expire_a: assert property (ce && wd_exp |=> sec_rst)
    else $error("watchdog expiry did not reset");
  fault_rst_a: assert property (ce && fi_any && !par_any |=> sec_rst && rst_cause == fmr_pkg::CAUSE_FAULT)
    else $error("fault detection did not reset");
  sec_rst_c: cover property (ce && wd_exp);
  exc_c: cover property (ce && |stk_viol);
  wr_resp_c: cover property (b_done && s_axi_bresp == fmr_pkg::RESP_OKAY);
endmodule
`default_nettype wire

// File: design/fmr_pkg.sv
`default_nettype none
package fmr_pkg;
  localparam int unsigned AXI_AW    = 8;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SENS     = 8'h04;
  localparam logic [7:0] OFF_WDLOAD   = 8'h08;
  localparam logic [7:0] OFF_WDKICK   = 8'h0C;
  localparam logic [7:0] OFF_RSTCAUSE = 8'h10;
  localparam logic [7:0] OFF_EXCCAUSE = 8'h14;
  localparam logic [7:0] OFF_HVSTAT   = 8'h18;
  localparam logic [7:0] OFF_ACTION   = 8'h1C;
  localparam logic [7:0] OFF_SPLIM0   = 8'h20;
  localparam logic [7:0] OFF_SPLIM1   = 8'h24;
  localparam logic [7:0] OFF_SPLIM2   = 8'h28;
  localparam int unsigned N_MODE    = 3;
  localparam int unsigned CTRL_DBLRD = 0;
  localparam int unsigned CTRL_WDEN  = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [31:0] WDLOAD_RST = 32'h0000_FFFF;
  localparam logic [15:0] ACTION_RST = 16'hFFFF;
  localparam int unsigned EXC_SENS  = 0;
  localparam int unsigned EXC_ECC   = 1;
  localparam int unsigned EXC_STK0  = 2;
  localparam int unsigned EXC_W     = 5;
  localparam int unsigned HV_BUSY   = 0;
  localparam int unsigned HV_DONE   = 1;
  localparam int unsigned HV_FAIL   = 2;
  localparam logic [2:0] CAUSE_POR    = 3'h1;
  localparam logic [2:0] CAUSE_SENS   = 3'h2;
  localparam logic [2:0] CAUSE_FAULT  = 3'h3;
  localparam logic [2:0] CAUSE_PARITY = 3'h4;
  localparam logic [2:0] CAUSE_WDOG   = 3'h5;
  localparam int unsigned FI_N      = 6;
  localparam int unsigned SP_W      = 16;
  localparam int unsigned RAM_DW    = 32;
  localparam int unsigned RAM_PW    = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SP_W-1:0] hi;
    logic [SP_W-1:0] lo;
  } fmr_lim_t;
  localparam fmr_lim_t LIM_RST = '{hi: 16'hFFFF, lo: 16'h0000};

  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} fmr_wst_t;

  // even parity, one bit per byte
  function automatic logic [RAM_PW-1:0] par(input logic [RAM_DW-1:0] d);
    logic [RAM_PW-1:0] p;
    for (int i = 0; i < RAM_PW; i++) p[i] = ^d[i*8 +: 8];
    return p;
  endfunction

  function automatic logic [15:0] lfsr_taps(input int unsigned aw);
    case (aw)
      8:       return 16'h00B8;
      10:      return 16'h0240;
      12:      return 16'h0E08;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_SPLIM2);
  endfunction
endpackage
`default_nettype wire

// File: design/fmr_stack.sv
`default_nettype none
module fmr_stack (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic                       act,
  input  wire logic                       sp_ld,
  input  wire logic [fmr_pkg::SP_W-1:0]   sp_in,
  input  wire fmr_pkg::fmr_lim_t          lim,
  output logic      [fmr_pkg::SP_W-1:0]   sp_r,
  output logic                            viol_r
);
  wire [fmr_pkg::SP_W-1:0] sp_nxt = (act && sp_ld) ? sp_in : sp_r;
  wire                     out_rng = (sp_nxt < lim.lo) || (sp_nxt > lim.hi);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_r   <= '0;
      viol_r <= 1'b0;
    end else if (ce) begin
      sp_r   <= sp_nxt;
      viol_r <= act && out_rng;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  stk_private_a: assert property (ce && !act |=> $stable(sp_r) && !viol_r)
    else $error("inactive stack pointer changed or flagged");
endmodule
`default_nettype wire

// File: design/fmr_scrub.sv
`default_nettype none
module fmr_scrub #(
  parameter int unsigned AW = 8
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic                         cpu_busy,
  input  wire logic                         rvalid,
  input  wire logic [fmr_pkg::RAM_DW-1:0]   rdata,
  input  wire logic [fmr_pkg::RAM_PW-1:0]   rpar,
  output logic                              req_r,
  output logic      [AW-1:0]                addr_r,
  output logic                              err_r
);
  localparam logic [15:0]   T16  = fmr_pkg::lfsr_taps(AW);
  localparam logic [AW-1:0] TAPS = T16[AW-1:0];
  localparam logic [AW-1:0] SEED = {{(AW-1){1'b0}}, 1'b1};

  if (T16 == 16'h0000) begin : g_chk
    $error("fmr_scrub: AW must be 8, 10 or 12");
  end

  logic [AW-1:0] lfsr_r;
  logic          zero_done_r;

  wire [AW-1:0] lfsr_nxt  = {1'b0, lfsr_r[AW-1:1]} ^ (lfsr_r[0] ? TAPS : '0);
  wire          issue     = !cpu_busy;
  wire          zero_turn = (lfsr_r == SEED) && !zero_done_r;
  wire          bad       = rvalid && (fmr_pkg::par(rdata) != rpar);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_r      <= SEED;
      zero_done_r <= 1'b0;
      req_r       <= 1'b0;
      addr_r      <= '0;
      err_r       <= 1'b0;
    end else if (ce) begin
      req_r <= issue;
      if (issue) begin
        addr_r      <= zero_turn ? '0 : lfsr_r;
        lfsr_r      <= zero_turn ? lfsr_r : lfsr_nxt;
        zero_done_r <= zero_turn;
      end
      err_r <= bad;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  scrub_yield_a: assert property (ce && cpu_busy |=> !req_r)
    else $error("scrubber accessed ram while cpu busy");
  scrub_err_a: assert property (ce && bad |=> err_r)
    else $error("scrub parity error not flagged");
  scrub_zero_c: cover property (ce && issue && zero_turn);
endmodule
`default_nettype wire

// File: verification/fmr_top_tb.sv
`default_nettype none
module fmr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, por_n = 0, ce = 1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, sens_oor = '0, cpu_wr_addr = '0;
  logic [31:0] s_axi_wdata = '0, ram_rd_data = '0, scrub_rdata = '0, cpu_wr_data = '0;
  logic [3:0] s_axi_wstrb = 4'hf, ram_rd_par = '0, scrub_rpar = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, inv_ecc_en = 0, ecc_err = 0, sp_ld = 0, ram_rd_valid = 0;
  logic cpu_ram_busy = 1, cpu_wr_en = 0, scrub_rvalid = 0, ee_wr_seq = 0, hv_low = 0;
  logic [5:0] fi_err = '0;
  logic [1:0] cpu_mode = '0, s_axi_bresp, s_axi_rresp;
  logic [15:0] sp_in = '0, sp_cur;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ram_we;
  logic scrub_req, ee_dbl_rd_en, sec_rst, exc_req;
  logic [31:0] s_axi_rdata, ram_wdata;
  logic [3:0] ram_wpar;
  logic [7:0] ram_waddr, scrub_addr;
  logic [2:0] rst_cause;
  logic [4:0] exc_cause;
  int errors = 0, cmp_count = 0;
  fmr_top i_fmr_top (.*);
  always #12.5 aclk = ~aclk;
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge aclk);
  endtask
  task automatic lim(int n);
    if (n > 100) begin
      errors++;
      $display("ERROR handshake exp ready got timeout");
      final_report;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
    int n;
    bit ad, wd;
    n = 0; ad = 0; wd = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      tick; n++; lim(n);
      if (!ad && s_axi_awready === 1'b1) begin ad = 1; s_axi_awvalid <= 0; end
      if (!wd && s_axi_wready === 1'b1) begin wd = 1; s_axi_wvalid <= 0; end
    end
    while (s_axi_bvalid !== 1'b1) begin tick; n++; lim(n); end
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin tick; n++; lim(n); end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do begin tick; n++; lim(n); end while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic t_regs;
    chk("rst_cause", fmr_pkg::CAUSE_POR, rst_cause);
    rd(fmr_pkg::OFF_CTRL, 32'h0000_0000);
    rd(fmr_pkg::OFF_SPLIM0, 32'hffff_0000);
    rd(8'h30, 32'h0000_0000, fmr_pkg::RESP_SLVERR);
    wr(8'h30, 32'h0000_0000, fmr_pkg::RESP_SLVERR);
    wr(fmr_pkg::OFF_CTRL, 32'h0000_0001);
    tick; #1 chk("dbl_rd", 1, ee_dbl_rd_en);
    tick; wr(fmr_pkg::OFF_CTRL, 32'h0000_0000);
    tick; #1 chk("dbl_rd", 0, ee_dbl_rd_en);
    tick; $display("regs test done");
  endtask
  task automatic t_sens;
    wr(fmr_pkg::OFF_SENS, 32'h0000_0000);
    rd(fmr_pkg::OFF_SENS, 32'h0000_00ff);
    sens_oor <= 8'h04; tick; sens_oor <= 8'h00;
    #1 chk("sec_rst", 1, sec_rst);
    chk("rst_cause", fmr_pkg::CAUSE_SENS, rst_cause);
    tick; wr(fmr_pkg::OFF_ACTION, 32'h0000_0000);
    sens_oor <= 8'h80; tick; sens_oor <= 8'h00;
    #1 chk("exc_req", 1, exc_req);
    chk("sec_rst", 0, sec_rst);
    tick; rd(fmr_pkg::OFF_EXCCAUSE, 32'h0000_0001);
    wr(fmr_pkg::OFF_EXCCAUSE, 32'h0000_0001);
    rd(fmr_pkg::OFF_EXCCAUSE, 32'h0000_0000);
    ecc_err <= 1; tick; ecc_err <= 0;
    #1 chk("exc_req", 0, exc_req);
    tick; inv_ecc_en <= 1; ecc_err <= 1; tick; ecc_err <= 0;
    #1 chk("exc_cause", 5'h02, exc_cause);
    tick; wr(fmr_pkg::OFF_EXCCAUSE, 32'h0000_0002);
    $display("sensor test done");
  endtask
  task automatic t_stack;
    wr(fmr_pkg::OFF_SPLIM0, 32'h0100_0010);
    sp_in <= 16'h0200; sp_ld <= 1; tick; sp_ld <= 0;
    tick(2); #1 chk("exc_cause", 5'h04, exc_cause);
    chk("sp_cur", 16'h0200, sp_cur);
    tick; cpu_mode <= 2'h1; sp_in <= 16'h0300; sp_ld <= 1; tick; sp_ld <= 0;
    cpu_mode <= 2'h0; tick(2);
    #1 chk("sp_cur", 16'h0200, sp_cur);
    tick; cpu_mode <= 2'h2; sp_in <= 16'h0400; sp_ld <= 1; tick; sp_ld <= 0; tick;
    #1 chk("sp_cur", 16'h0400, sp_cur);
    tick; cpu_mode <= 2'h3; tick(2);
    #1 chk("sp_cur", 16'h0000, sp_cur);
    tick; cpu_mode <= 2'h0;
    tick; sp_in <= 16'h0050; sp_ld <= 1; tick; sp_ld <= 0; tick(3);
    wr(fmr_pkg::OFF_EXCCAUSE, 32'h0000_001c);
    rd(fmr_pkg::OFF_EXCCAUSE, 32'h0000_0000);
    hv_low <= 1; ee_wr_seq <= 1; tick(2); hv_low <= 0; tick; ee_wr_seq <= 0; tick(2);
    #1 chk("exc_req", 0, exc_req);
    tick; rd(fmr_pkg::OFF_HVSTAT, 32'h0000_0006);
    $display("stack and hv test done");
  endtask
  task automatic t_par;
    int n;
    logic [255:0] seen;
    ram_rd_data <= 32'h0000_0003; ram_rd_par <= 4'h0; ram_rd_valid <= 1; tick;
    ram_rd_valid <= 0;
    #1 chk("sec_rst", 0, sec_rst);
    tick; cpu_wr_en <= 1; cpu_wr_addr <= 8'h12; cpu_wr_data <= 32'h0001_0300; tick;
    cpu_wr_en <= 0; #1 chk("ram_wpar", 4'h4, ram_wpar);
    chk("ram_we", 1, ram_we);
    chk("ram_waddr", 8'h12, ram_waddr);
    chk("ram_wdata", 32'h0001_0300, ram_wdata);
    tick; ram_rd_par <= 4'h0; ram_rd_data <= 32'h0000_0001; ram_rd_valid <= 1; tick;
    ram_rd_valid <= 0;
    #1 chk("sec_rst", 1, sec_rst);
    chk("rst_cause", fmr_pkg::CAUSE_PARITY, rst_cause);
    tick; cpu_ram_busy <= 0; tick(2);
    #1 chk("scrub_req", 1, scrub_req);
    seen = '0;
    repeat (256) begin
      tick; seen[scrub_addr] = 1'b1;
    end
    chk("scrub_all", 1, &seen);
    cpu_ram_busy <= 1; tick(2);
    #1 chk("scrub_req", 0, scrub_req);
    tick; scrub_rdata <= 32'h0000_0100; scrub_rpar <= 4'h0; scrub_rvalid <= 1; tick;
    scrub_rvalid <= 0; tick;
    #1 chk("sec_rst", 1, sec_rst);
    for (int i = 0; i < 6; i++) begin
      tick; fi_err <= 6'h01 << i; tick; fi_err <= '0;
      #1 chk("sec_rst", 1, sec_rst);
      chk("rst_cause", fmr_pkg::CAUSE_FAULT, rst_cause);
    end
    tick; aresetn <= 0; tick(2); aresetn <= 1; tick(2);
    ce <= 0; sens_oor <= 8'h01; tick(2); ce <= 1; sens_oor <= 8'h00;
    #1 chk("sec_rst", 0, sec_rst);
    tick; rd(fmr_pkg::OFF_RSTCAUSE, fmr_pkg::CAUSE_FAULT);
    rd(fmr_pkg::OFF_ACTION, 32'h0000_00ff);
    wr(fmr_pkg::OFF_WDLOAD, 32'h0000_0008);
    wr(fmr_pkg::OFF_CTRL, 32'h0000_0002);
    wr(fmr_pkg::OFF_CTRL, 32'h0000_0000);
    rd(fmr_pkg::OFF_CTRL, 32'h0000_0002);
    n = 0;
    do begin tick; n++; lim(n); end while (sec_rst !== 1'b1);
    chk("rst_cause", fmr_pkg::CAUSE_WDOG, rst_cause);
    n = 0;
    do begin tick; n++; lim(n); end while (sec_rst !== 1'b1);
    chk("wd_period", 9, n);
    $display("parity and fault test done");
  endtask
  initial begin
    tick(8);
    aresetn <= 1; por_n <= 1; tick(2);
    t_regs; t_sens; t_stack; t_par;
    final_report;
  end
endmodule
`default_nettype wire
